// File: design/dmsc_cmd.v
// ATA command interpreter for block-count setup, sleep and monitoring
// subcommands, with task-file registers on an AHB-Lite slave.
// Assumes one clock hclk at 250 MHz and a single whole-word AHB master.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dmsc_consts.vh"

// Operation
// RL1 - Command C6h with good count stores block size for read/write multiple.
// RL2 - Host loads sector count with 2..128, a power of two.
// RL3 - Unsupported block count aborts the setup command.
// RL4 - Setup command sets BSY first, then checks sector count.
// RL5 - Device accepts its reported maximum block size and smaller ones.
// RL6 - Host issues commands only while DRDY is one.
// RL7 - 99h and E6h mean sleep; abort without power management.
// RL8 - Sleep sets BSY, prepares, clears BSY, raises INTRQ.
// RL9 - Host reads Status to clear interrupt and allow sleep entry.
// RL10 - Unread interrupt drops and sleep starts after at least 2 s.
// RL11 - Host leaves command registers alone while asleep.
// RL12 - Only software or hardware reset wakes the device.
// RL13 - Never power on asleep nor stay asleep after reset.
// RL14 - Monitoring subcommands need cylinder 4Fh/C2h and valid feature.
// RL15 - D9h turns off all monitoring, timers and attribute saving.
// RL16 - Monitoring enable state survives power cycles.
// RL17 - While monitoring disabled, abort all subcommands except enable.
// RL18 - Monitoring disable sets BSY, disables, clears BSY, raises INTRQ.
// RL19 - D2h with 00h disables autosave, F1h enables, other vendor meaning.
// RL20 - Autosave state and non-zero setting survive power cycles.
// RL21 - Supported autosave sets BSY, changes it, clears BSY, INTRQ.
// RL22 - Autosave keeps BSY low, DRDY high; answer commands within 2 s.
// RL23 - Abort sets ERR and ABRT, clears BSY, raises INTRQ.
module dmsc_cmd #(
  parameter [7:0]  MAX_BLK    = `DMSC_R_MAXBLK,
  parameter [31:0] SLEEP_CYC  = `DMSC_T_SLEEP_CYC,
  parameter [7:0]  PREP_CYC   = `DMSC_T_PREP
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Persisted settings loaded at power-on (nonvolatile store)
  input  wire        nv_mon_en,
  input  wire [7:0]  nv_autosave,
  output wire        nv_wr,
  output wire        nv_mon_out,
  output wire [7:0]  nv_autosave_out,
  // Device state toward the rest of the drive
  output wire        intrq,
  output wire        sleeping,
  output wire        multiple_en,
  output wire [7:0]  block_size,
  output wire        mon_active,
  output wire        autosave_en
);

  // **********************************************************
  // Bus slave
  // **********************************************************
  // Command states: idle, executing, sleep waiting on status read, asleep
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_BUSY  = 2'd1;
  localparam [1:0] ST_PEND  = 2'd2;
  localparam [1:0] ST_SLEEP = 2'd3;
  // Last count of the pending period; a status read up to it still wins
  localparam [31:0] SLEEP_LAST = SLEEP_CYC - 32'h1;

  // Bus phase registers
  reg        wr_ph_ff;
  reg        rd_ph_ff;
  reg [7:0]  ad_ff;
  reg [31:0] hrdata_ff;

  // Command state and task file
  reg [1:0]  st_ff;
  reg [7:0]  cmd_ff;
  reg [7:0]  feat_ff;
  reg [7:0]  sc_ff;
  reg [7:0]  cl_ff;
  reg [7:0]  ch_ff;

  // Status and handshake
  reg        bsy_ff;
  reg        err_ff;
  reg        abrt_ff;
  reg        intrq_ff;

  // Settings
  reg        pm_ff;
  reg        blk_ok_ff;
  reg [7:0]  blk_ff;
  reg        mon_ff;
  reg [7:0]  as_ff;
  reg        nv_wr_ff;
  reg        load_ff;

  // Timers
  reg [7:0]  prep_ff;
  reg [31:0] slp_cnt_ff;

  // Registers are whole words only; narrower accesses are ignored
  wire       word_acc = (hsize == 3'b010);
  wire       take     = hsel & hready & htrans[1] & word_acc;

  // Status byte; DRDY drops while busy and while asleep
  reg  [7:0] stat;
  always @*
  begin
    stat               = 8'h00;
    stat[`DMSC_S_BSY]  = bsy_ff;
    stat[`DMSC_S_DRDY] = ~bsy_ff & (st_ff != ST_SLEEP);
    stat[`DMSC_S_ERR]  = err_ff;
  end

  // Address phase capture; every access answers in one data cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      ad_ff    <= 8'h00;
    end
    else
    begin
      wr_ph_ff <= take & hwrite;
      rd_ph_ff <= take & ~hwrite;
      ad_ff    <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read data; unmapped addresses read zero
  wire       rd_now = take & ~hwrite;
  reg [31:0] nxt_rd;
  always @*
  begin
    nxt_rd = 32'h0;
    if (haddr[7:0] == `DMSC_A_FEAT)
      nxt_rd = {24'h0, feat_ff};
    else if (haddr[7:0] == `DMSC_A_SECCNT)
      nxt_rd = {24'h0, sc_ff};
    else if (haddr[7:0] == `DMSC_A_CYLLO)
      nxt_rd = {24'h0, cl_ff};
    else if (haddr[7:0] == `DMSC_A_CYLHI)
      nxt_rd = {24'h0, ch_ff};
    else if (haddr[7:0] == `DMSC_A_STATUS || haddr[7:0] == `DMSC_A_ALTSTAT)
      nxt_rd = {24'h0, stat};
    else if (haddr[7:0] == `DMSC_A_ERROR)
      nxt_rd[`DMSC_E_ABRT] = abrt_ff;
    else if (haddr[7:0] == `DMSC_A_STATE)
      nxt_rd = {14'h0, st_ff, as_ff, blk_ff};
    else if (haddr[7:0] == `DMSC_A_CONFIG)
      nxt_rd = {23'h0, mon_ff, 7'h00, pm_ff};
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0;
    else if (rd_now)
      hrdata_ff <= nxt_rd;
  end
  assign hrdata = hrdata_ff;

  // **********************************************************
  // Command decode
  // **********************************************************
  wire wr_cmd  = wr_ph_ff & (ad_ff == `DMSC_A_CMD);
  wire wr_srst = wr_ph_ff & (ad_ff == `DMSC_A_RESET) & hwdata[2];
  // Status read (not alternate status) acknowledges the interrupt
  wire rd_stat = rd_ph_ff & (ad_ff == `DMSC_A_STATUS);
  // Opcode is taken from the write data in the command's data phase
  wire [7:0] c = hwdata[7:0];

  // Explicit match keeps zero, one and odd counts out of the block size
  wire pow2 = (sc_ff == 8'h02) | (sc_ff == 8'h04) | (sc_ff == 8'h08) |
              (sc_ff == 8'h10) | (sc_ff == 8'h20) | (sc_ff == 8'h40) |
              (sc_ff == 8'h80);
  wire blk_good = pow2 & (sc_ff <= MAX_BLK);                // RL3 RL5
  wire sig_ok   = (cl_ff == `DMSC_K_CYLLO) & (ch_ff == `DMSC_K_CYLHI); // RL14

  // **********************************************************
  // Command state machine
  // **********************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff      <= ST_IDLE;                                 // RL13
      cmd_ff     <= 8'h00;
      feat_ff    <= 8'h00;
      sc_ff      <= 8'h00;
      cl_ff      <= 8'h00;
      ch_ff      <= 8'h00;
      bsy_ff     <= 1'b0;
      err_ff     <= 1'b0;
      abrt_ff    <= 1'b0;
      intrq_ff   <= 1'b0;
      pm_ff      <= 1'b1;
      blk_ok_ff  <= 1'b0;
      blk_ff     <= `DMSC_R_BLK;
      mon_ff     <= 1'b0;
      as_ff      <= 8'h00;
      nv_wr_ff   <= 1'b0;
      load_ff    <= 1'b1;
      prep_ff    <= 8'h00;
    end
    else
    begin
      nv_wr_ff <= 1'b0;
      // Persisted settings taken once after reset release
      if (load_ff)
      begin
        load_ff <= 1'b0;
        mon_ff  <= nv_mon_en;                                // RL16
        as_ff   <= nv_autosave;                              // RL20
      end
      // Config write, ignored while busy
      if (wr_ph_ff && ad_ff == `DMSC_A_CONFIG && !bsy_ff)
        pm_ff <= hwdata[`DMSC_G_PM];
      // Soft reset wakes the device and clears the handshake
      if (wr_srst)
      begin
        st_ff    <= ST_IDLE;                                 // RL12
        bsy_ff   <= 1'b0;
        intrq_ff <= 1'b0;
        err_ff   <= 1'b0;
        abrt_ff  <= 1'b0;
      end
      else
      begin
        case (st_ff)
          ST_IDLE, ST_PEND:
          begin
            // Task-file writes while idle or waiting to sleep
            if (wr_ph_ff && ad_ff == `DMSC_A_FEAT)
              feat_ff <= hwdata[7:0];
            if (wr_ph_ff && ad_ff == `DMSC_A_SECCNT)
              sc_ff <= hwdata[7:0];
            if (wr_ph_ff && ad_ff == `DMSC_A_CYLLO)
              cl_ff <= hwdata[7:0];
            if (wr_ph_ff && ad_ff == `DMSC_A_CYLHI)
              ch_ff <= hwdata[7:0];
            if (rd_stat)
              intrq_ff <= 1'b0;
            // Status read after sleep completion lets sleep begin
            if (st_ff == ST_PEND && rd_stat)
              st_ff <= ST_SLEEP;                             // RL9
            else if (st_ff == ST_PEND && slp_cnt_ff == SLEEP_LAST)
            begin
              intrq_ff <= 1'b0;                              // RL10
              st_ff    <= ST_SLEEP;
            end
            // A new command wins over pending sleep
            if (wr_cmd)
            begin
              cmd_ff   <= c;
              bsy_ff   <= 1'b1;                              // RL4 RL8 RL18 RL21
              intrq_ff <= 1'b0;
              err_ff   <= 1'b0;
              abrt_ff  <= 1'b0;
              prep_ff  <= PREP_CYC;
              st_ff    <= ST_BUSY;
            end
          end
          ST_BUSY:
          begin
            if (prep_ff != 8'h00)
              prep_ff <= prep_ff - 8'h01;
            else
            begin
              // BSY drops and INTRQ rises on one edge, aborted or not
              bsy_ff     <= 1'b0;
              intrq_ff   <= 1'b1;                            // RL23
              st_ff      <= ST_IDLE;
              if (cmd_ff == `DMSC_C_SETMULT)
              begin
                if (blk_good)
                begin
                  blk_ff    <= sc_ff;                        // RL1
                  blk_ok_ff <= 1'b1;
                end
                else
                begin
                  err_ff  <= 1'b1;                           // RL3
                  abrt_ff <= 1'b1;
                end
              end
              else if (cmd_ff == `DMSC_C_SLEEP1 || cmd_ff == `DMSC_C_SLEEP2)
              begin
                if (pm_ff)
                  st_ff <= ST_PEND;                          // RL7 RL8
                else
                begin
                  err_ff  <= 1'b1;                           // RL7
                  abrt_ff <= 1'b1;
                end
              end
              else if (cmd_ff == `DMSC_C_MON && sig_ok &&
                       feat_ff == `DMSC_F_MONON)
              begin
                mon_ff   <= 1'b1;
                nv_wr_ff <= ~mon_ff;
              end
              else if (cmd_ff == `DMSC_C_MON && sig_ok && mon_ff &&
                       feat_ff == `DMSC_F_MONOFF)
              begin
                mon_ff   <= 1'b0;                            // RL15 RL18
                nv_wr_ff <= 1'b1;                            // RL16
              end
              else if (cmd_ff == `DMSC_C_MON && sig_ok && mon_ff &&
                       feat_ff == `DMSC_F_AUTOSV)
              begin
                as_ff    <= sc_ff;                           // RL19 RL21
                nv_wr_ff <= 1'b1;                            // RL20
              end
              else
              begin
                // Bad signature, feature, disabled monitoring or unknown
                err_ff  <= 1'b1;                             // RL14 RL17 RL23
                abrt_ff <= 1'b1;
              end
            end
          end
          default:
          begin
            // Asleep: only reset leaves; task-file and command writes are dropped
            st_ff <= ST_SLEEP;                               // RL12
          end
        endcase
      end
    end
  end

  // Sleep timer; runs only while sleep waits on the status read, so each
  // pending period starts from zero and a new command stops it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slp_cnt_ff <= 32'h0;
    else if (st_ff == ST_PEND)
      slp_cnt_ff <= slp_cnt_ff + 32'h1;                      // RL10
    else
      slp_cnt_ff <= 32'h0;
  end

  // **********************************************************
  // Outputs
  // **********************************************************
  // Handshake and power state
  assign intrq           = intrq_ff;
  assign sleeping        = (st_ff == ST_SLEEP);
  assign multiple_en     = blk_ok_ff;                        // RL1
  assign block_size      = blk_ff;
  // Monitoring timers gated off when disabled
  assign mon_active      = mon_ff;                           // RL15
  // Autosave runs in the background and never touches BSY or DRDY
  assign autosave_en     = mon_ff & (as_ff != `DMSC_K_ASOFF); // RL19 RL22
  // Store write port: live settings, strobed by a one-cycle nv_wr
  assign nv_wr           = nv_wr_ff;
  assign nv_mon_out      = mon_ff;
  assign nv_autosave_out = as_ff;

endmodule // dmsc_cmd
`default_nettype wire

// File: design/dmsc_consts.vh
// Constants for the ATA multiple-mode, sleep and monitoring command block.
// Assumes inclusion by bare name from design files.
`ifndef DMSC_CONSTS_VH
`define DMSC_CONSTS_VH
// Register byte addresses on the AHB-Lite slave
`define DMSC_A_CMD      8'h00
`define DMSC_A_FEAT     8'h04
`define DMSC_A_SECCNT   8'h08
`define DMSC_A_CYLLO    8'h0c
`define DMSC_A_CYLHI    8'h10
`define DMSC_A_STATUS   8'h14
`define DMSC_A_ERROR    8'h18
`define DMSC_A_ALTSTAT  8'h1c
`define DMSC_A_STATE    8'h20
`define DMSC_A_CONFIG   8'h24
`define DMSC_A_RESET    8'h28
// Command and subcommand codes
`define DMSC_C_SETMULT  8'hc6
`define DMSC_C_SLEEP1   8'h99
`define DMSC_C_SLEEP2   8'he6
`define DMSC_C_MON      8'hb0
`define DMSC_F_MONOFF   8'hd9
`define DMSC_F_MONON    8'hd8
`define DMSC_F_AUTOSV   8'hd2
`define DMSC_K_CYLLO    8'h4f
`define DMSC_K_CYLHI    8'hc2
`define DMSC_K_ASOFF    8'h00
`define DMSC_K_ASON     8'hf1
// Status and error bit positions
`define DMSC_S_BSY      7
`define DMSC_S_DRDY     6
`define DMSC_S_ERR      0
`define DMSC_E_ABRT     2
// Config bit positions
`define DMSC_G_PM       0
// Reset values
`define DMSC_R_BLK      8'h00
`define DMSC_R_MAXBLK   8'h80
// Timing: autonomous sleep delay, milliseconds, and clock rate in MHz
`define DMSC_T_SLEEP_MS 2000
`define DMSC_T_CLK_MHZ  250
`define DMSC_T_SLEEP_CYC (`DMSC_T_SLEEP_MS * 1000 * `DMSC_T_CLK_MHZ)
// Busy time of every command, in clocks after the first busy cycle
`define DMSC_T_PREP     8'h04
`endif

// File: sim/dmsc_chk.sv
// Port checker for the command block.
// Assumes it is bound onto dmsc_cmd and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "dmsc_consts.vh"
// ****
// Checker
// ****
module dmsc_chk #(
  parameter [7:0] MAX_BLK = 8'h80
) (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Device state
  input wire logic        intrq,
  input wire logic        sleeping,
  input wire logic        multiple_en,
  input wire logic [7:0]  block_size,
  input wire logic        mon_active,
  input wire logic        autosave_en,
  input wire logic        nv_mon_out,
  // Settings store port
  input wire logic        nv_wr,
  input wire logic        nv_mon_en
);
  logic acc;
  logic cmd_ff;
  logic rst_ff;
  logic sr1_ff;
  logic sr2_ff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Write address phases, carried into the data phase
  assign acc = hsel && hready && htrans[1] && hwrite;
  // Soft reset is remembered two cycles, as wake-up may lag the write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_ff <= 1'b0;
      rst_ff <= 1'b0;
      sr1_ff <= 1'b0;
      sr2_ff <= 1'b0;
    end
    else
    begin
      cmd_ff <= acc && (haddr[7:0] == `DMSC_A_CMD);
      rst_ff <= acc && (haddr[7:0] == `DMSC_A_RESET);
      sr1_ff <= rst_ff && hwdata[2];
      sr2_ff <= sr1_ff;
    end
  end
  a_cmd_irq: assert property (cmd_ff |=> !intrq [*3] ##[1:8] intrq)
    else $error("no interrupt after command");
  a_asleep_quiet: assert property (sleeping |-> !intrq)
    else $error("interrupt while asleep");
  a_wake_reset: assert property ($fell(sleeping) |-> sr1_ff || sr2_ff)
    else $error("woke without reset");
  a_reset_awake: assert property ($rose(hresetn) |-> !sleeping && !intrq)
    else $error("asleep after reset");
  a_blk_legal: assert property (multiple_en |-> $onehot(block_size) &&
    block_size >= 8'h02 && block_size <= MAX_BLK) else $error("bad block size");
  a_blk_off: assert property (!multiple_en |-> block_size == 8'h00)
    else $error("block size without enable");
  a_autosave_gate: assert property (!mon_active |-> !autosave_en)
    else $error("autosave while monitoring off");
  a_mon_saved: assert property ($changed(mon_active) |-> (nv_wr && nv_mon_out == mon_active) ||
    mon_active == nv_mon_en) else $error("monitor state not stored");
  cover property ($rose(sleeping));
  cover property ($fell(mon_active));
  cover property ($rose(intrq));
endmodule // dmsc_chk

bind dmsc_cmd dmsc_chk #(.MAX_BLK(MAX_BLK)) dmsc_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .intrq(intrq),
  .sleeping(sleeping), .multiple_en(multiple_en), .block_size(block_size),
  .mon_active(mon_active), .autosave_en(autosave_en), .nv_mon_out(nv_mon_out),
  .nv_wr(nv_wr), .nv_mon_en(nv_mon_en));
`default_nettype wire

// File: sim/dmsc_nvm.sv
// Model of the nonvolatile settings store beside the device.
// Assumes the device pulses nv_wr with the values to keep.
`timescale 1ns/100ps
`default_nettype none
// ****
// Store
// ****
module dmsc_nvm (
  // Clock
  input  wire logic       hclk,
  // Write port from the device
  input  wire logic       nv_wr,
  input  wire logic       nv_mon_out,
  input  wire logic [7:0] nv_autosave_out,
  // Stored values
  output var  logic       nv_mon_en,
  output var  logic [7:0] nv_autosave
);
  // Blank store; it has no reset, so contents outlive device resets
  initial
  begin
    nv_mon_en = 1'b0;
    nv_autosave = 8'h00;
  end
  // Take a write only when strobed
  always @(posedge hclk)
  begin
    if (nv_wr)
    begin
      nv_mon_en <= nv_mon_out;
      nv_autosave <= nv_autosave_out;
    end
  end
endmodule // dmsc_nvm
`default_nettype wire

// File: sim/test_dmsc_cmd.sv
// Self-checking bench for the command block.
// Assumes the design, its constants header and the store model.
`timescale 1ns/100ps
`default_nettype none
`include "dmsc_consts.vh"
// ****
// Bench
// ****
module test_dmsc_cmd;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] f;
    logic [7:0] s;
    logic       ab;
    logic       mon;
    logic       as;
  } dmsc_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] r;
  logic [7:0]  cyl_lo = 8'h4f;
  wire logic   hready, hresp, nv_mon_en, nv_wr, nv_mon_out, intrq;
  wire logic   sleeping, multiple_en, mon_active, autosave_en;
  wire logic [7:0]  nv_autosave, nv_autosave_out, block_size;
  wire logic [31:0] hrdata;
  int          fail_count = 0;
  int          n_compared = 0;
  int          i;
  dmsc_row_t   rows [13] = '{
    '{8'hc6, 8'h00, 8'h03, 1'b1, 1'b0, 1'b0}, '{8'hc6, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'hc6, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0}, '{8'hb0, 8'hd9, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'hb0, 8'hd2, 8'hf1, 1'b1, 1'b0, 1'b0}, '{8'hb0, 8'hd8, 8'h00, 1'b0, 1'b1, 1'b0},
    '{8'hb0, 8'hd2, 8'hf1, 1'b0, 1'b1, 1'b1}, '{8'hb0, 8'hd2, 8'h00, 1'b0, 1'b1, 1'b0},
    '{8'hb0, 8'hd2, 8'hf1, 1'b0, 1'b1, 1'b1}, '{8'hb0, 8'hd9, 8'h00, 1'b0, 1'b0, 1'b0},
    '{8'hb0, 8'hd9, 8'h00, 1'b1, 1'b0, 1'b0}, '{8'hb0, 8'hd8, 8'h00, 1'b0, 1'b1, 1'b1},
    '{8'hb0, 8'hd5, 8'h00, 1'b1, 1'b1, 1'b1}};

  // Sleep delay shortened so the run stays short
  dmsc_cmd #(.SLEEP_CYC(32'd50)) dmsc_cmd_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .nv_mon_en(nv_mon_en),
    .nv_autosave(nv_autosave), .nv_wr(nv_wr), .nv_mon_out(nv_mon_out),
    .nv_autosave_out(nv_autosave_out), .intrq(intrq), .sleeping(sleeping),
    .multiple_en(multiple_en), .block_size(block_size), .mon_active(mon_active),
    .autosave_en(autosave_en));
  dmsc_nvm dmsc_nvm_i (
    .hclk(hclk), .nv_wr(nv_wr), .nv_mon_out(nv_mon_out),
    .nv_autosave_out(nv_autosave_out), .nv_mon_en(nv_mon_en), .nv_autosave(nv_autosave));

  // 250 MHz clock
  always #2 hclk = ~hclk;

  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, s, e);
    end
  endtask

  // A spent wait bound counts as a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      fail_count++;
      summarize();
    end
  endtask

  // One single AHB transfer; read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
    r = hrdata;
    tmo(n);
  endtask

  // Load the task file, issue a command, wait for its interrupt
  task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s);
    int n;
    n = 0;
    xfer(1'b1, `DMSC_A_FEAT, {24'h0, f});
    xfer(1'b1, `DMSC_A_SECCNT, {24'h0, s});
    xfer(1'b1, `DMSC_A_CYLLO, {24'h0, cyl_lo});
    xfer(1'b1, `DMSC_A_CYLHI, 32'hc2);
    xfer(1'b0, `DMSC_A_ALTSTAT, 32'h0);
    chk(r[7:6], 2'b01);
    xfer(1'b1, `DMSC_A_CMD, {24'h0, c});
    xfer(1'b0, `DMSC_A_ALTSTAT, 32'h0);
    chk(r[7:6], 2'b10);
    do @(posedge hclk); while (intrq !== 1'b1 && ++n < 40);
    tmo(n);
  endtask

  // Completion: error flag, then status read which clears the interrupt
  task automatic fin(input logic ab);
    xfer(1'b0, `DMSC_A_ERROR, 32'h0);
    chk(r[2], ab);
    xfer(1'b0, `DMSC_A_STATUS, 32'h0);
    chk(r, {24'h0, 2'b01, 5'h0, ab});
  endtask

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({sleeping, intrq, multiple_en, block_size}, 11'h0);
    xfer(1'b0, `DMSC_A_CONFIG, 32'h0);
    chk(r, 32'h1);
    for (i = 1; i < 8; i++)
    begin
      issue(8'hc6, 8'h00, 8'h01 << i);
      fin(1'b0);
      chk({multiple_en, block_size}, {1'b1, 8'h01 << i});
    end
    $display("block size test done");
    for (i = 0; i < 13; i++)
    begin
      issue(rows[i].c, rows[i].f, rows[i].s);
      fin(rows[i].ab);
      chk({block_size, mon_active, autosave_en}, {8'h80, rows[i].mon, rows[i].as});
      $display("row %0d done", i);
    end
    // Wrong cylinder key
    cyl_lo = 8'h4e;
    issue(8'hb0, 8'hd2, 8'h00);
    fin(1'b1);
    chk(autosave_en, 1'b1);
    cyl_lo = 8'h4f;
    $display("key test done");
    // Sleep after status read, then soft reset keeps settings
    issue(8'h99, 8'h00, 8'h00);
    fin(1'b0);
    repeat (2) @(posedge hclk);
    chk({sleeping, intrq}, 2'b10);
    xfer(1'b1, `DMSC_A_RESET, 32'h4);
    repeat (2) @(posedge hclk);
    chk({sleeping, block_size}, {1'b0, 8'h80});
    $display("sleep test done");
    // No power management: sleep refused; unmapped read gives zero
    xfer(1'b1, `DMSC_A_CONFIG, 32'h0);
    xfer(1'b0, `DMSC_A_CONFIG, 32'h0);
    chk(r, 32'h100);
    issue(8'he6, 8'h00, 8'h00);
    fin(1'b1);
    repeat (2) @(posedge hclk);
    chk(sleeping, 1'b0);
    xfer(1'b1, `DMSC_A_CONFIG, 32'h1);
    xfer(1'b0, 8'h3c, 32'h0);
    chk(r, 32'h0);
    $display("refusal test done");
    // Unread interrupt: device sleeps alone, hard reset wakes it
    issue(8'he6, 8'h00, 8'h00);
    repeat (20) @(posedge hclk);
    chk({intrq, sleeping}, 2'b10);
    repeat (60) @(posedge hclk);
    chk({intrq, sleeping}, 2'b01);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({sleeping, intrq, multiple_en, block_size}, 11'h0);
    chk({mon_active, autosave_en}, 2'b11);
    xfer(1'b0, `DMSC_A_STATE, 32'h0);
    chk(r[15:8], 8'hf1);
    $display("timeout test done");
    summarize();
  end
endmodule // test_dmsc_cmd
`default_nettype wire
